/* File: design/hb_serial_pkg.sv */
package hb_serial_pkg;

    localparam int WORD_W = 16;
    localparam int CNT_W = 4;
    localparam int BRIDGES = 10;
    localparam int LOW_N = 6;
    localparam int HIGH_N = 4;

    // Control word fields, same layout for both groups.
    localparam int CTL_CLEAR = 15;
    localparam int CTL_GROUP = 14;
    localparam int CTL_OLSD = 13;
    localparam int CTL_EN_LSB = 7;
    localparam int CTL_CNF_LSB = 1;
    localparam int CTL_OVERVOLTAGE_LOCKOUT_ENABLE = 0;

    // Diagnosis word fields.
    localparam int DIAG_OC = 15;
    localparam int DIAG_PSF = 14;
    localparam int DIAG_OLD = 13;
    localparam int DIAG_ACT_LSB = 7;
    localparam int DIAG_CNF_LSB = 1;
    localparam int DIAG_TW = 0;

    localparam logic [WORD_W-1:0] CTL_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [BRIDGES-1:0] BRIDGES_OFF = 10'h000;
    localparam logic [BRIDGES-1:0] LOW_MASK = 10'h03F;
    localparam logic [BRIDGES-1:0] HIGH_MASK = 10'h3C0;

    localparam int GRP_LOW = 0;
    localparam int GRP_HIGH = 1;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic sdi;
    } serial_pins_t;

    // Levels that the host holds on the pins between frames.
    localparam serial_pins_t PINS_IDLE = '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

    typedef struct packed {
        logic [BRIDGES-1:0] overcurrent;
        logic [BRIDGES-1:0] open_load;
        logic thermal_shutdown;
        logic thermal_warning;
        logic undervoltage;
        logic overvoltage;
    } fault_in_t;

    localparam int SYNC_W = $bits(serial_pins_t) + $bits(fault_in_t);
    localparam logic [SYNC_W-1:0] SYNC_RESET = {PINS_IDLE, {$bits(fault_in_t){1'b0}}};

    typedef enum {
        LINK_IDLE,
        LINK_SHIFT
    } link_state_t;

    // Spreads one per-group bit over the ten bridges.
    function automatic logic [BRIDGES-1:0] group_spread(input logic low_bit, input logic high_bit);
        group_spread = {{HIGH_N{high_bit}}, {LOW_N{low_bit}}};
    endfunction

endpackage

/* File: design/serial_sync.sv */
`timescale 1ns/100ps

module serial_sync
    import hb_serial_pkg::*;
#(
    parameter int WIDTH = SYNC_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // The first stage feeds only the second; metastability settles there.
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            // Resetting to the idle pin levels keeps a false edge from following reset.
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: design/half_bridge_serial_control.sv */
`timescale 1ns/100ps

module half_bridge_serial_control
    import hb_serial_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire serial_pins_t pins,
    input wire fault_in_t faults,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [BRIDGES-1:0] bridge_active,
    output logic [BRIDGES-1:0] bridge_high_select,
    output logic frame_error
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and pin edges.

    logic [SYNC_W-1:0] sync_bus;
    serial_pins_t pins_s;
    fault_in_t faults_s;

    serial_sync #(
        .WIDTH(SYNC_W),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({pins, faults}),
        .sync_out(sync_bus)
    );

    assign {pins_s, faults_s} = sync_bus;

    logic sel_n_dly_reg;
    logic sclk_dly_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sel_n_dly_reg <= 1'b1;
            sclk_dly_reg <= 1'b0;
        end else begin
            sel_n_dly_reg <= pins_s.sel_n;
            sclk_dly_reg <= pins_s.sclk;
        end
    end

    wire sel_fall = sel_n_dly_reg & ~pins_s.sel_n;
    wire sel_rise = ~sel_n_dly_reg & pins_s.sel_n;
    wire sclk_fall = sclk_dly_reg & ~pins_s.sclk;
    wire sclk_rise = ~sclk_dly_reg & pins_s.sclk;

    ////////////////////////////////////////////////////////////////////////////
    // Frame engine.

    link_state_t state_reg;
    link_state_t state_next;
    logic [WORD_W-1:0] shift_in_reg;
    logic [WORD_W-1:0] shift_out_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic got_edge_reg;
    logic [WORD_W-1:0] ctl_low_reg;
    logic [WORD_W-1:0] ctl_high_reg;
    logic group_reg;
    logic [1:0] oc_flag_reg;
    logic [1:0] old_flag_reg;
    logic tsd_flag_reg;
    logic [BRIDGES-1:0] oc_off_reg;
    logic [BRIDGES-1:0] ol_off_reg;

    wire shifting = (state_reg == LINK_SHIFT);
    wire frame_end = shifting & sel_rise;
    wire frame_good = got_edge_reg & (bit_cnt_reg == CNT_ZERO);
    wire apply_w = frame_end & frame_good;
    wire new_group = shift_in_reg[CTL_GROUP];
    wire clear_cmd = apply_w & shift_in_reg[CTL_CLEAR];
    wire clear_low = clear_cmd & ~new_group;
    wire clear_high = clear_cmd & new_group;
    wire [BRIDGES-1:0] clear_mask = (clear_low ? LOW_MASK : BRIDGES_OFF) | (clear_high ? HIGH_MASK : BRIDGES_OFF);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LINK_IDLE: begin
                if (sel_fall) begin
                    state_next = LINK_SHIFT;
                end
            end
            LINK_SHIFT: begin
                if (sel_rise) begin
                    state_next = LINK_IDLE;
                end
            end
            default: begin
                state_next = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= LINK_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Only the last sixteen bits survive; longer frames simply shift older bits out.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shift_in_reg <= WORD_ZERO;
            bit_cnt_reg <= CNT_ZERO;
            got_edge_reg <= 1'b0;
        end else if (sel_fall) begin
            bit_cnt_reg <= CNT_ZERO;
            got_edge_reg <= 1'b0;
        end else if (shifting && sclk_fall) begin
            shift_in_reg <= {shift_in_reg[WORD_W-2:0], pins_s.sdi};
            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
            got_edge_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            frame_error <= 1'b0;
        end else begin
            frame_error <= frame_end & ~frame_good;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, one per group.

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_low_reg <= CTL_RESET;
            ctl_high_reg <= CTL_RESET;
            group_reg <= 1'b0;
        end else if (apply_w) begin
            group_reg <= new_group;
            if (new_group) begin
                ctl_high_reg <= shift_in_reg;
            end else begin
                ctl_low_reg <= shift_in_reg;
            end
        end
    end

    wire [BRIDGES-1:0] enable_vec = {ctl_high_reg[CTL_EN_LSB +: HIGH_N], ctl_low_reg[CTL_EN_LSB +: LOW_N]};
    wire [BRIDGES-1:0] cnf_vec = {ctl_high_reg[CTL_CNF_LSB +: HIGH_N], ctl_low_reg[CTL_CNF_LSB +: LOW_N]};
    wire [BRIDGES-1:0] olsd_mask = group_spread(ctl_low_reg[CTL_OLSD], ctl_high_reg[CTL_OLSD]);
    wire overvoltage_lockout_enable_enable = ctl_low_reg[CTL_OVERVOLTAGE_LOCKOUT_ENABLE] | ctl_high_reg[CTL_OVERVOLTAGE_LOCKOUT_ENABLE];
    wire psf_level = faults_s.undervoltage | faults_s.overvoltage;
    wire psf_off = faults_s.undervoltage | (faults_s.overvoltage & overvoltage_lockout_enable_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Fault latches. A fault arriving with its clear is kept: set wins.

    wire [BRIDGES-1:0] oc_ev = faults_s.overcurrent;
    wire [BRIDGES-1:0] ol_ev = faults_s.open_load;
    wire [BRIDGES-1:0] ol_shut_ev = ol_ev & olsd_mask;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            oc_off_reg <= BRIDGES_OFF;
            ol_off_reg <= BRIDGES_OFF;
            oc_flag_reg <= 2'h0;
            old_flag_reg <= 2'h0;
            tsd_flag_reg <= 1'b0;
        end else begin
            oc_off_reg <= (oc_off_reg & ~clear_mask) | oc_ev;
            ol_off_reg <= (ol_off_reg & ~clear_mask) | ol_shut_ev;
            oc_flag_reg[GRP_LOW] <= (oc_flag_reg[GRP_LOW] & ~clear_low) | (|oc_ev[LOW_N-1:0]);
            oc_flag_reg[GRP_HIGH] <= (oc_flag_reg[GRP_HIGH] & ~clear_high) | (|oc_ev[BRIDGES-1:LOW_N]);
            old_flag_reg[GRP_LOW] <= (old_flag_reg[GRP_LOW] & ~clear_low) | (|ol_ev[LOW_N-1:0]);
            old_flag_reg[GRP_HIGH] <= (old_flag_reg[GRP_HIGH] & ~clear_high) | (|ol_ev[BRIDGES-1:LOW_N]);
            tsd_flag_reg <= (tsd_flag_reg & ~clear_cmd) | faults_s.thermal_shutdown;
        end
    end

    // No per-bridge thermal sensor is seen here, so thermal shutdown turns every bridge off.
    wire global_off = psf_off | tsd_flag_reg;
    wire [BRIDGES-1:0] latched_off = oc_off_reg | ol_off_reg;
    wire [BRIDGES-1:0] active_next = enable_vec & ~latched_off & ~{BRIDGES{global_off}};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bridge_active <= BRIDGES_OFF;
            bridge_high_select <= BRIDGES_OFF;
        end else begin
            bridge_active <= active_next;
            bridge_high_select <= cnf_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diagnosis word and serial output.

    logic [WORD_W-1:0] diag_low_w;
    logic [WORD_W-1:0] diag_high_w;

    always_comb begin
        diag_low_w = WORD_ZERO;
        diag_low_w[DIAG_OC] = oc_flag_reg[GRP_LOW];
        diag_low_w[DIAG_PSF] = psf_level;
        diag_low_w[DIAG_OLD] = old_flag_reg[GRP_LOW];
        diag_low_w[DIAG_ACT_LSB +: LOW_N] = bridge_active[LOW_N-1:0];
        diag_low_w[DIAG_CNF_LSB +: LOW_N] = bridge_high_select[LOW_N-1:0];
        diag_low_w[DIAG_TW] = faults_s.thermal_warning;
        diag_high_w = WORD_ZERO;
        diag_high_w[DIAG_OC] = oc_flag_reg[GRP_HIGH];
        diag_high_w[DIAG_PSF] = psf_level;
        diag_high_w[DIAG_OLD] = old_flag_reg[GRP_HIGH];
        diag_high_w[DIAG_ACT_LSB +: HIGH_N] = bridge_active[BRIDGES-1:LOW_N];
        diag_high_w[DIAG_CNF_LSB +: HIGH_N] = bridge_high_select[BRIDGES-1:LOW_N];
        diag_high_w[DIAG_TW] = faults_s.thermal_warning;
    end

    wire [WORD_W-1:0] diag_sel = group_reg ? diag_high_w : diag_low_w;

    // The word is frozen at select fall so the host reads one consistent snapshot.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            shift_out_reg <= WORD_ZERO;
        end else if (sel_fall) begin
            serial_out_oe <= 1'b1;
            serial_out <= tsd_flag_reg;
            shift_out_reg <= diag_sel;
        end else if (frame_end) begin
            serial_out_oe <= 1'b0;
            serial_out <= 1'b0;
        end else if (shifting && sclk_rise) begin
            serial_out <= shift_out_reg[WORD_W-1];
            shift_out_reg <= {shift_out_reg[WORD_W-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    chk_apply_at_rise: assert property (
        ($changed(ctl_low_reg) || $changed(ctl_high_reg)) |-> $past(apply_w)
    ) else $error("Control word changed outside a good frame end.");

    chk_bad_frame_keep: assert property (
        (frame_end && !frame_good) |=> ($stable(ctl_low_reg) && $stable(ctl_high_reg))
    ) else $error("Bad frame altered the control registers.");

    chk_load_group: assert property (
        (apply_w && !shift_in_reg[CTL_GROUP]) |=> (ctl_low_reg == $past(shift_in_reg)) && !group_reg
    ) else $error("Low group word not loaded.");

    chk_error_count: assert property (
        (frame_end && (bit_cnt_reg != CNT_ZERO || !got_edge_reg)) |=> frame_error
    ) else $error("Frame with wrong bit count not flagged.");

    chk_sample_fall: assert property (
        (shifting && sclk_fall && !sel_fall) |=> (shift_in_reg[0] == $past(pins_s.sdi))
    ) else $error("Input bit not taken on falling clock.");

    chk_pseudo_bit: assert property (
        sel_fall |=> (serial_out_oe && serial_out == $past(tsd_flag_reg))
    ) else $error("Thermal pseudo bit not presented at select fall.");

    chk_oe_release: assert property (
        frame_end |=> !serial_out_oe ##1 (!serial_out_oe || $past(sel_fall))
    ) else $error("Output still driven after select rose.");

    chk_out_on_rise: assert property (
        ($changed(serial_out) && shifting && $past(shifting) && !$past(sel_fall)) |-> $past(sclk_rise)
    ) else $error("Output changed without a rising clock.");

    chk_supply_off: assert property (
        psf_off |=> (bridge_active == BRIDGES_OFF)
    ) else $error("Bridges active during supply fault.");

    chk_oc_hold: assert property (
        (oc_flag_reg[GRP_LOW] && !clear_low) |=> oc_flag_reg[GRP_LOW]
    ) else $error("Overcurrent flag lost without clear.");

    chk_olsd_latch: assert property (
        (|ol_shut_ev) |=> ((ol_off_reg & $past(ol_shut_ev)) == $past(ol_shut_ev))
    ) else $error("Open load did not latch the bridge off.");

    chk_latched_off: assert property (
        (|latched_off) |=> ((bridge_active & $past(latched_off)) == BRIDGES_OFF)
    ) else $error("Latched-off bridge still active.");

    chk_tsd_hold: assert property (
        (tsd_flag_reg && !clear_cmd) |=> tsd_flag_reg
    ) else $error("Thermal flag lost without clear.");

    chk_thermal_off: assert property (
        tsd_flag_reg |=> (bridge_active == BRIDGES_OFF)
    ) else $error("Bridges active after thermal shutdown.");

    chk_old_latch: assert property (
        (|ol_ev[BRIDGES-1:LOW_N]) |=> old_flag_reg[GRP_HIGH]
    ) else $error("Open load flag not latched.");

    chk_clear_old: assert property (
        (clear_high && !(|ol_ev[BRIDGES-1:LOW_N])) |=> !old_flag_reg[GRP_HIGH]
    ) else $error("Clear command left the open load flag set.");

    chk_oe_idle: assert property (
        !shifting |-> !serial_out_oe
    ) else $error("Output driven outside a frame.");

    chk_count_restart: assert property (
        sel_fall |=> ((bit_cnt_reg == CNT_ZERO) && !got_edge_reg)
    ) else $error("Bit count not restarted at select fall.");

    cov_good_frame: cover property (apply_w);
    cov_bad_frame: cover property (frame_end && !frame_good);
    cov_clear_cmd: cover property (clear_cmd && oc_flag_reg != 2'h0);
    cov_group_high: cover property (apply_w && new_group);
    cov_tsd_pseudo: cover property (sel_fall && tsd_flag_reg);

endmodule

/* File: tb/host_model.sv */
`timescale 1ns/100ps
module host_model
    import hb_serial_pkg::*;
(
    input wire logic clk_sys,
    output serial_pins_t pins,
    input wire logic do_line
);
    // Clock and data rest low between frames so the pseudo bit reads valid.
    initial pins = '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
    ////////////////////////////////////////////////////////////////
    // Half a link period; long enough for the three-flop input path.
    task automatic gap();
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic xfer(input logic [31:0] d, input int n, output logic [WORD_W:0] rx, output logic oe);
        rx = '0;
        @(negedge clk_sys);
        pins.sel_n = 1'b0;
        gap();
        rx[WORD_W] = do_line;
        oe = (do_line !== 1'bz);
        for (int i = 0; i < n; i++) begin
            pins.sdi = d[n-1-i];
            pins.sclk = 1'b1;
            gap();
            if (i < WORD_W) rx[WORD_W-1-i] = do_line;
            pins.sclk = 1'b0;
            gap();
        end
        pins.sdi = 1'b0;
        pins.sel_n = 1'b1;
        gap();
    endtask
endmodule

/* File: tb/half_bridge_serial_control_tb_top.sv */
`timescale 1ns/100ps
module half_bridge_serial_control_tb_top;
    import hb_serial_pkg::*;
    logic clk_sys;
    logic sys_rst;
    serial_pins_t pins;
    fault_in_t faults;
    logic serial_out;
    logic serial_out_oe;
    logic [BRIDGES-1:0] bridge_active;
    logic [BRIDGES-1:0] bridge_high_select;
    logic frame_error;
    wire do_line;
    int n_fail;
    int checks;
    int n_err = 0;
    int err_mark;
    int seed;
    logic [WORD_W-1:0] ctl_lo;
    logic [WORD_W-1:0] ctl_hi;
    logic [BRIDGES-1:0] off;
    logic tsd_f;
    logic sup_off;
    logic grp;
    logic [WORD_W:0] rx;
    logic oe_seen;
    logic [WORD_W-1:0] w;
    int lens[8] = '{16, 32, 0, 15, 17, 1, 16, 31};

    assign do_line = serial_out_oe ? serial_out : 1'bz;
    always #5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (frame_error === 1'b1) n_err <= n_err + 1;

    half_bridge_serial_control u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins), .faults(faults),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .bridge_active(bridge_active),
        .bridge_high_select(bridge_high_select), .frame_error(frame_error));
    host_model u_host (.clk_sys(clk_sys), .pins(pins), .do_line(do_line));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Direction of a floating bridge is not defined, so only active ones are compared.
    function automatic logic [BRIDGES-1:0] exp_act();
        return {ctl_hi[10:7], ctl_lo[12:7]} & ~off & ~{BRIDGES{tsd_f | sup_off}};
    endfunction
    function automatic logic [BRIDGES-1:0] exp_cnf();
        return {ctl_hi[4:1], ctl_lo[6:1]} & exp_act();
    endfunction
    task automatic settle();
        repeat (8) @(negedge clk_sys);
        chk("active", 32'(exp_act()), 32'(bridge_active));
    endtask
    task automatic frame(input logic [31:0] d, input int n);
        int e0;
        e0 = n_err;
        u_host.xfer(d, n, rx, oe_seen);
        if (n > 0 && n % 16 == 0) begin
            grp = d[CTL_GROUP];
            if (grp) ctl_hi = d[15:0] & 16'h7FFF;
            else ctl_lo = d[15:0] & 16'h7FFF;
            if (d[CTL_CLEAR]) begin
                tsd_f = 1'b0;
                off = off & ~(grp ? HIGH_MASK : LOW_MASK);
            end
        end
        chk("frame_error", 32'(n == 0 || n % 16 != 0), 32'(n_err - e0));
        chk("oe_in_frame", 32'h1, 32'(oe_seen));
        chk("oe_idle", 32'h0, 32'(serial_out_oe));
        chk("active", 32'(exp_act()), 32'(bridge_active));
        chk("high_sel", 32'(exp_cnf()), 32'(bridge_high_select & bridge_active));
    endtask
    // Rewrites the current group unchanged and checks the returned word; f is tsd, oc, psf, old, tw.
    task automatic rd(input logic [4:0] f);
        logic [WORD_W:0] e;
        logic [BRIDGES-1:0] a;
        logic [BRIDGES-1:0] c;
        a = exp_act();
        c = exp_cnf();
        e = grp ? {f[4:1], 2'h0, a[9:6], 2'h0, c[9:6], f[0]} : {f[4:1], a[5:0], c[5:0], f[0]};
        frame(32'(grp ? ctl_hi : ctl_lo), 16);
        chk("diag", 32'(e), 32'({rx[16:7], rx[6:1] & rx[12:7], rx[0]}));
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        #1ms;
        n_fail++;
        complete_run();
    end
    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        faults = '0;
        {n_fail, checks} = '0;
        seed = 32'hBDBAA714;
        {ctl_lo, ctl_hi, off, tsd_f, sup_off, grp} = '0;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("rst_act", 32'h0, 32'(bridge_active));
        chk("rst_oe", 32'h0, 32'(serial_out_oe));
        chk("rst_err", 32'h0, 32'(n_err));
        rd(5'h00);
        for (int k = 0; k < 8; k++) begin
            w = 16'($random(seed));
            w[CTL_CLEAR] = 1'b0;
            frame({16'($random(seed)), w}, lens[k]);
            rd(5'h00);
        end
        frame(32'h1FD4, 16);
        frame(32'h478A, 16);
        // Overload on bridge 2 latches it off until a clear of its group.
        faults.overcurrent[1] = 1'b1;
        off[1] = 1'b1;
        settle();
        faults.overcurrent[1] = 1'b0;
        frame(32'h1FD4, 16);
        rd(5'h08);
        frame(32'h9FD4, 16);
        rd(5'h00);
        // Open load on bridge 8, first with shutdown off, then on.
        faults.open_load[7] = 1'b1;
        settle();
        faults.open_load[7] = 1'b0;
        frame(32'h478A, 16);
        rd(5'h02);
        frame(32'h678A, 16);
        frame(32'hE78A, 16);
        faults.open_load[7] = 1'b1;
        off[7] = 1'b1;
        settle();
        faults.open_load[7] = 1'b0;
        rd(5'h02);
        frame(32'hC78A, 16);
        rd(5'h00);
        // Thermal shutdown latches and leads the word as the pseudo bit.
        faults.thermal_shutdown = 1'b1;
        faults.thermal_warning = 1'b1;
        tsd_f = 1'b1;
        settle();
        faults.thermal_shutdown = 1'b0;
        rd(5'h11);
        faults.thermal_warning = 1'b0;
        frame(32'hC78A, 16);
        rd(5'h00);
        // Supply faults: undervoltage always forces off, overvoltage only with lockout.
        faults.undervoltage = 1'b1;
        sup_off = 1'b1;
        settle();
        rd(5'h04);
        faults.undervoltage = 1'b0;
        sup_off = 1'b0;
        settle();
        faults.overvoltage = 1'b1;
        settle();
        rd(5'h04);
        sup_off = 1'b1;
        frame(32'h1FD5, 16);
        faults.overvoltage = 1'b0;
        sup_off = 1'b0;
        settle();
        rd(5'h00);
        // Latch an overload, then reset in mid-run: both groups and every latch must clear.
        faults.overcurrent[3] = 1'b1;
        off[3] = 1'b1;
        settle();
        faults.overcurrent[3] = 1'b0;
        err_mark = n_err;
        sys_rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        {ctl_lo, ctl_hi, off, tsd_f, sup_off, grp} = '0;
        repeat (4) @(negedge clk_sys);
        chk("rst2_act", 32'h0, 32'(bridge_active));
        chk("rst2_err", 32'(err_mark), 32'(n_err));
        rd(5'h00);
        complete_run();
    end
endmodule
